// ==== design/ump_pkg.sv ====
// Shared constants for the multiprocessor serial port: register map,
// control bit positions, reset values and frame state codes.
// Assumes one 40 MHz clock; baud timing is a plain divider count.
package ump_pkg;

   // Register indices; byte address is four times the index
   localparam logic [7:0] CTRL_INDEX = 8'h98;
   localparam logic [7:0] DATA_INDEX = 8'h99;
   localparam int ADR_W = 12;
   localparam logic [ADR_W-1:0] CTRL_ADDR = {2'h0, CTRL_INDEX, 2'h0};
   localparam logic [ADR_W-1:0] DATA_ADDR = {2'h0, DATA_INDEX, 2'h0};

   // Control register field positions
   localparam int BIT_MODE9 = 7;
   localparam int BIT_FIXED = 6;
   localparam int BIT_MCE = 5;
   localparam int BIT_REN = 4;
   localparam int BIT_TB8 = 3;
   localparam int BIT_RB8 = 2;
   localparam int BIT_TI = 1;
   localparam int BIT_RI = 0;
   localparam logic [7:0] CTRL_RESET = 8'h40;

   // Data bits per frame and default baud divider (115200 at 40 MHz)
   localparam logic [3:0] DATA_BITS8 = 4'h8;
   localparam logic [3:0] DATA_BITS9 = 4'h9;
   localparam logic [15:0] BAUD_DIV_DEFAULT = 16'h015b;

   // Frame sequencer states, shared by transmit and receive
   typedef enum logic [1:0] {
      FR_IDLE = 2'b00,
      FR_START = 2'b01,
      FR_DATA = 2'b10,
      FR_STOP = 2'b11
   } ump_frame_t;

endpackage : ump_pkg

// ==== design/ump_link_if.sv ====
// Serial line between the port and its partner processor.
// Assumes both ends idle high and share the bench clock.
`timescale 1ns/1ps
interface ump_link_if;
   // Line driven by the port
   logic dev_txd;
   // Line driven by the partner
   logic far_txd;

   modport dev (output dev_txd, input far_txd);
   modport far (output far_txd, input dev_txd);
endinterface : ump_link_if

// ==== design/ump_device.sv ====
// Serial port with multiprocessor addressing and a classic Wishbone slave.
// Assumes the baud divider is fixed by parameter and far_txd is synchronous.
//
// Overview of operation
// - Mode bit picks 8-bit or 9-bit frames
// - Master sends address byte before data bytes
// - Address ninth bit one, data ninth zero
// - Nine-bit with enable: flag only addresses
// - Nine-bit without enable: ninth bit ignored
// - Eight-bit: enable checks stop bit high
// - Matching slave clears enable for data
// - Unaddressed slaves keep enable, stay quiet
// - Several addresses per slave allowed, broadcast
// - Receive only while receive enable set
// - Nine-bit mode sends tx ninth bit
// - Ninth receive bit: stop or ninth
// - Transmit flag set at stop start
// - Receive flag set at stop sampling
// - Hardware never clears the done flags
// - Enabled flags raise the interrupt request
// - Bit six reads one, writes ignored
// - Control at 0x98, reset value 0x40
`timescale 1ns/1ps
module ump_device #(
   parameter logic [15:0] BAUD_DIV = ump_pkg::BAUD_DIV_DEFAULT
) (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [ump_pkg::ADR_W-1:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Processor interrupt side
   input wire logic irq_enable,
   output logic serial_irq,
   // Serial line
   ump_link_if.dev link
);
   import ump_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] rx_buf;
      logic [7:0] rd_dat;
      logic ack;
      ump_frame_t tx_st;
      logic [15:0] tx_cnt;
      logic [3:0] tx_bit;
      logic [8:0] tx_shift;
      logic txd;
      ump_frame_t rx_st;
      logic [15:0] rx_cnt;
      logic [3:0] rx_bit;
      logic [8:0] rx_shift;
   } ump_dev_state_t;

   ump_dev_state_t s;
   ump_dev_state_t next_s;

   localparam logic [15:0] HALF_DIV = BAUD_DIV >> 1;
   localparam logic [15:0] LAST_CNT = BAUD_DIV - 16'h0001;

   logic access;
   logic wr_ctrl;
   logic wr_data;
   logic set_ti;
   logic set_ri;
   logic [3:0] frame_bits;
   logic [7:0] rd_mux;

   ////////////////////////////////////////////////////////////////////////
   // Bus decode; a write lands on the edge where ack is seen high
   assign access = wb_cyc_i && wb_stb_i;
   assign wr_ctrl = access && s.ack && wb_we_i && wb_sel_i[0] && (wb_adr_i == CTRL_ADDR);
   assign wr_data = access && s.ack && wb_we_i && wb_sel_i[0] && (wb_adr_i == DATA_ADDR);
   assign frame_bits = s.ctrl[BIT_MODE9] ? DATA_BITS9 : DATA_BITS8;

   // Read data; unmapped addresses read zero
   always_comb begin
      if (wb_adr_i == CTRL_ADDR) begin
         rd_mux = s.ctrl;
      end else if (wb_adr_i == DATA_ADDR) begin
         rd_mux = s.rx_buf;
      end else begin
         rd_mux = 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic for bus, transmitter and receiver
   always_comb begin
      next_s = s;
      set_ti = 1'b0;
      set_ri = 1'b0;
      // One-cycle ack, dropped the cycle after it is given
      next_s.ack = access && !s.ack;
      if (access && !s.ack) begin
         next_s.rd_dat = rd_mux;
      end
      if (wr_ctrl) begin
         next_s.ctrl = wb_dat_i[7:0] | (8'h01 << BIT_FIXED);
      end

      // Transmitter; writes while busy are dropped
      unique case (s.tx_st)
         FR_IDLE: begin
            next_s.txd = 1'b1;
            if (wr_data) begin
               next_s.tx_shift = {s.ctrl[BIT_TB8], wb_dat_i[7:0]};
               next_s.tx_cnt = 16'h0000;
               next_s.tx_bit = 4'h0;
               next_s.txd = 1'b0;
               next_s.tx_st = FR_START;
            end
         end
         FR_START, FR_DATA: begin
            next_s.tx_cnt = s.tx_cnt + 16'h0001;
            if (s.tx_cnt == LAST_CNT) begin
               next_s.tx_cnt = 16'h0000;
               if (s.tx_st == FR_DATA && s.tx_bit == frame_bits) begin
                  next_s.txd = 1'b1;
                  next_s.tx_st = FR_STOP;
                  set_ti = 1'b1;
               end else begin
                  next_s.txd = s.tx_shift[0];
                  next_s.tx_shift = {1'b0, s.tx_shift[8:1]};
                  next_s.tx_bit = s.tx_bit + 4'h1;
                  next_s.tx_st = FR_DATA;
               end
            end
         end
         FR_STOP: begin
            next_s.tx_cnt = s.tx_cnt + 16'h0001;
            if (s.tx_cnt == LAST_CNT) begin
               next_s.tx_st = FR_IDLE;
            end
         end
      endcase

      // Receiver; sampling at mid-bit
      unique case (s.rx_st)
         FR_IDLE: begin
            if (s.ctrl[BIT_REN] && !link.far_txd) begin
               next_s.rx_cnt = 16'h0000;
               next_s.rx_bit = 4'h0;
               next_s.rx_st = FR_START;
            end
         end
         FR_START: begin
            next_s.rx_cnt = s.rx_cnt + 16'h0001;
            if (s.rx_cnt == HALF_DIV) begin
               next_s.rx_cnt = 16'h0000;
               // Glitch shorter than half a bit is dropped
               next_s.rx_st = link.far_txd ? FR_IDLE : FR_DATA;
            end
         end
         FR_DATA: begin
            next_s.rx_cnt = s.rx_cnt + 16'h0001;
            if (s.rx_cnt == LAST_CNT) begin
               next_s.rx_cnt = 16'h0000;
               next_s.rx_bit = s.rx_bit + 4'h1;
               // LSB first into a right shifter
               if (s.ctrl[BIT_MODE9]) begin
                  next_s.rx_shift = {link.far_txd, s.rx_shift[8:1]};
               end else begin
                  next_s.rx_shift = {1'b0, link.far_txd, s.rx_shift[7:1]};
               end
               if (s.rx_bit + 4'h1 == frame_bits) begin
                  next_s.rx_st = FR_STOP;
               end
            end
         end
         FR_STOP: begin
            next_s.rx_cnt = s.rx_cnt + 16'h0001;
            if (s.rx_cnt == LAST_CNT) begin
               next_s.rx_st = FR_IDLE;
               if (s.ctrl[BIT_MODE9]) begin
                  next_s.ctrl[BIT_RB8] = s.rx_shift[8];
                  set_ri = !s.ctrl[BIT_MCE] || s.rx_shift[8];
               end else begin
                  next_s.ctrl[BIT_RB8] = link.far_txd;
                  set_ri = !s.ctrl[BIT_MCE] || link.far_txd;
               end
               if (set_ri) begin
                  next_s.rx_buf = s.rx_shift[7:0];
               end
            end
         end
      endcase
      // disabling aborts a frame in flight
      if (!s.ctrl[BIT_REN]) begin
         next_s.rx_st = FR_IDLE;
         set_ri = 1'b0;
      end

      // only software clears; set beats a clear
      if (set_ti) begin
         next_s.ctrl[BIT_TI] = 1'b1;
      end
      if (set_ri) begin
         next_s.ctrl[BIT_RI] = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // reset value with bit six set
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         s <= '{ctrl: CTRL_RESET, rx_buf: 8'h00, rd_dat: 8'h00, ack: 1'b0,
                tx_st: FR_IDLE, tx_cnt: 16'h0000, tx_bit: 4'h0, tx_shift: 9'h000,
                txd: 1'b1, rx_st: FR_IDLE, rx_cnt: 16'h0000, rx_bit: 4'h0,
                rx_shift: 9'h000};
      end else begin
         s <= next_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs
   assign wb_ack_o = s.ack;
   assign wb_dat_o = {24'h000000, s.rd_dat};
   assign link.dev_txd = s.txd;
   assign serial_irq = irq_enable && (s.ctrl[BIT_TI] || s.ctrl[BIT_RI]);

endmodule : ump_device

// ==== design/ump_partner.sv ====
// Partner processor's serial end: sends address or data frames and
// reports every received frame with its ninth and stop bits.
// Assumes the same baud divider as the port and a synchronous line.
`timescale 1ns/1ps
module ump_partner #(
   parameter logic [15:0] BAUD_DIV = ump_pkg::BAUD_DIV_DEFAULT
) (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Frame format
   input wire logic nine_bit_mode,
   // Transmit request
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   input wire logic tx_is_address,
   output logic tx_ready,
   // Receive report
   output logic rx_valid,
   output logic [7:0] rx_data,
   output logic rx_ninth,
   output logic rx_stop,
   // Serial line
   ump_link_if.far link
);
   import ump_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      ump_frame_t tx_st;
      logic [15:0] tx_cnt;
      logic [3:0] tx_bit;
      logic [8:0] tx_shift;
      logic txd;
      ump_frame_t rx_st;
      logic [15:0] rx_cnt;
      logic [3:0] rx_bit;
      logic [8:0] rx_shift;
      logic valid;
      logic [7:0] data;
      logic ninth;
      logic stop;
   } ump_far_state_t;

   ump_far_state_t s;
   ump_far_state_t next_s;

   localparam logic [15:0] HALF_DIV = BAUD_DIV >> 1;
   localparam logic [15:0] LAST_CNT = BAUD_DIV - 16'h0001;

   logic [3:0] frame_bits;

   assign frame_bits = nine_bit_mode ? DATA_BITS9 : DATA_BITS8;

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb begin
      next_s = s;
      next_s.valid = 1'b0;
      unique case (s.tx_st)
         FR_IDLE: begin
            next_s.txd = 1'b1;
            if (tx_valid) begin
               next_s.tx_shift = {tx_is_address, tx_data};
               next_s.tx_cnt = 16'h0000;
               next_s.tx_bit = 4'h0;
               next_s.txd = 1'b0;
               next_s.tx_st = FR_START;
            end
         end
         FR_START, FR_DATA: begin
            next_s.tx_cnt = s.tx_cnt + 16'h0001;
            if (s.tx_cnt == LAST_CNT) begin
               next_s.tx_cnt = 16'h0000;
               if (s.tx_st == FR_DATA && s.tx_bit == frame_bits) begin
                  next_s.txd = 1'b1;
                  next_s.tx_st = FR_STOP;
               end else begin
                  next_s.txd = s.tx_shift[0];
                  next_s.tx_shift = {1'b0, s.tx_shift[8:1]};
                  next_s.tx_bit = s.tx_bit + 4'h1;
                  next_s.tx_st = FR_DATA;
               end
            end
         end
         FR_STOP: begin
            next_s.tx_cnt = s.tx_cnt + 16'h0001;
            if (s.tx_cnt == LAST_CNT) begin
               next_s.tx_st = FR_IDLE;
            end
         end
      endcase

      // Receiver samples mid-bit and always reports
      unique case (s.rx_st)
         FR_IDLE: begin
            if (!link.dev_txd) begin
               next_s.rx_cnt = 16'h0000;
               next_s.rx_bit = 4'h0;
               next_s.rx_st = FR_START;
            end
         end
         FR_START: begin
            next_s.rx_cnt = s.rx_cnt + 16'h0001;
            if (s.rx_cnt == HALF_DIV) begin
               next_s.rx_cnt = 16'h0000;
               next_s.rx_st = link.dev_txd ? FR_IDLE : FR_DATA;
            end
         end
         FR_DATA: begin
            next_s.rx_cnt = s.rx_cnt + 16'h0001;
            if (s.rx_cnt == LAST_CNT) begin
               next_s.rx_cnt = 16'h0000;
               next_s.rx_bit = s.rx_bit + 4'h1;
               if (nine_bit_mode) begin
                  next_s.rx_shift = {link.dev_txd, s.rx_shift[8:1]};
               end else begin
                  next_s.rx_shift = {1'b0, link.dev_txd, s.rx_shift[7:1]};
               end
               if (s.rx_bit + 4'h1 == frame_bits) begin
                  next_s.rx_st = FR_STOP;
               end
            end
         end
         FR_STOP: begin
            next_s.rx_cnt = s.rx_cnt + 16'h0001;
            if (s.rx_cnt == LAST_CNT) begin
               next_s.rx_st = FR_IDLE;
               next_s.valid = 1'b1;
               next_s.data = s.rx_shift[7:0];
               // ninth bit tells address from data
               next_s.ninth = s.rx_shift[8];
               next_s.stop = link.dev_txd;
            end
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         s <= '{tx_st: FR_IDLE, tx_cnt: 16'h0000, tx_bit: 4'h0, tx_shift: 9'h000,
                txd: 1'b1, rx_st: FR_IDLE, rx_cnt: 16'h0000, rx_bit: 4'h0,
                rx_shift: 9'h000, valid: 1'b0, data: 8'h00, ninth: 1'b0, stop: 1'b0};
      end else begin
         s <= next_s;
      end
   end

   // Outputs; ready is the idle transmitter
   assign tx_ready = (s.tx_st == FR_IDLE);
   assign rx_valid = s.valid;
   assign rx_data = s.data;
   assign rx_ninth = s.ninth;
   assign rx_stop = s.stop;
   assign link.far_txd = s.txd;

endmodule : ump_partner

// ==== bench/ump_properties.sv ====
// Checker for the serial port: bus answer, interrupt and line timing.
// Assumes it sits beside the link interface with the divider of both ends.
`timescale 1ns/1ps
module ump_properties #(
   parameter logic [15:0] BAUD_DIV = ump_pkg::BAUD_DIV_DEFAULT
) (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Bus and interrupt
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic wb_ack_o,
   input wire logic irq_enable,
   input wire logic serial_irq,
   // Serial lines
   input wire logic dev_txd,
   input wire logic far_txd
);
   ////////////////////////////////////////////////////////////////////////
   // Run lengths per line; idle runs are unbounded, so only low runs checked
   logic [15:0] dev_run;
   logic [15:0] far_run;
   logic dev_prev;
   logic far_prev;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         dev_run <= 16'h0000;
         far_run <= 16'h0000;
         dev_prev <= 1'b1;
         far_prev <= 1'b1;
      end else begin
         dev_prev <= dev_txd;
         far_prev <= far_txd;
         dev_run <= (dev_txd != dev_prev) ? 16'h0001 : dev_run + 16'h0001;
         far_run <= (far_txd != far_prev) ? 16'h0001 : far_run + 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);

   a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
   a_ack_next_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not answered in one cycle");
   a_ack_needs_request: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   a_irq_masked: assert property (!irq_enable |-> !serial_irq) else $error("irq while disabled");
   a_irq_no_hwclear: assert property ($fell(serial_irq) |-> !irq_enable || $past(wb_ack_o && wb_we_i))
      else $error("done flag dropped without a write");
   // Long idle then a fall is a start bit, which only a data write may launch
   a_frame_needs_write: assert property ($fell(dev_txd) && int'(dev_run) > 8 * int'(BAUD_DIV) |->
      $past(wb_ack_o && wb_we_i)) else $error("frame started without a write");
   a_dev_bit_width: assert property (!dev_prev && dev_txd |-> (dev_run % BAUD_DIV) == 16'h0000)
      else $error("device low run not whole bits");
   a_far_bit_width: assert property (!far_prev && far_txd |-> (far_run % BAUD_DIV) == 16'h0000)
      else $error("partner low run not whole bits");
endmodule : ump_properties

// ==== bench/uart_multiprocessor_control_tb.sv ====
// Testbench: serial port and partner end face each other over the link.
// Assumes both ends share one short divider and the 40 MHz clock.
`timescale 1ns/1ps
module uart_multiprocessor_control_tb;
   import ump_pkg::*;
   localparam logic [15:0] BDIV = 16'h0008;
   // Two addresses owned by the slave under test
   localparam logic [7:0] MY_ADDR_A = 8'h3c;
   localparam logic [7:0] MY_ADDR_B = 8'h51;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, irq_en = 1'b0, ack, irq;
   logic [ADR_W-1:0] adr = '0;
   logic [31:0] wdat = 32'h0, rdo, rdat;
   logic nine = 1'b0, ptx_v = 1'b0, ptx_a = 1'b0, ptx_rdy, prx_v, prx_ninth, prx_stop;
   logic [7:0] ptx_d = 8'h00, prx_d, ad;
   logic [31:0] lfsr = 32'h4874;
   logic f, ren;
   int err_total = 0, checks = 0, cycles = 0, rx_count = 0, n0;
   ump_link_if lnk ();

   ump_device #(.BAUD_DIV(BDIV)) ump_device_inst (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_sel_i(4'h1), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdo), .wb_ack_o(ack),
      .irq_enable(irq_en), .serial_irq(irq), .link(lnk));
   ump_partner #(.BAUD_DIV(BDIV)) ump_partner_inst (.clk(clk), .sys_rst(sys_rst), .nine_bit_mode(nine),
      .tx_valid(ptx_v), .tx_data(ptx_d), .tx_is_address(ptx_a), .tx_ready(ptx_rdy), .rx_valid(prx_v),
      .rx_data(prx_d), .rx_ninth(prx_ninth), .rx_stop(prx_stop), .link(lnk));
   ump_properties #(.BAUD_DIV(BDIV)) ump_properties_inst (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_ack_o(ack), .irq_enable(irq_en), .serial_irq(irq),
      .dev_txd(lnk.dev_txd), .far_txd(lnk.far_txd));

   ////////////////////////////////////////////////////////////////////////
   // Clock, frame counter and hang guard
   always #12.5 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (prx_v === 1'b1) rx_count++;
      if (cycles > 10000) begin
         err_total++;
         conclude();
      end
   end

   task automatic conclude;
      if (err_total == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : conclude

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // Classic single cycle; waits for ack, takes read data at that edge
   task automatic wb(input logic w, input logic [ADR_W-1:0] a, input logic [7:0] d);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {24'h0, d};
      // Ack ends this wait; without ack only the run's cycle ceiling ends it
      do @(posedge clk); while (ack !== 1'b1);
      rdat = rdo;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : wb

   // Partner frame: request held until taken, then frame waited out
   task automatic psend(input logic [7:0] d, input logic a);
      ptx_d <= d;
      ptx_a <= a;
      ptx_v <= 1'b1;
      do @(posedge clk); while (ptx_rdy !== 1'b1);
      ptx_v <= 1'b0;
      @(posedge clk);
      for (int n = 0; n < 300 && ptx_rdy !== 1'b1; n++) @(posedge clk);
      repeat (16) @(posedge clk);
   endtask : psend

   // slave software answers to two addresses
   function automatic logic mine(input logic [7:0] a);
      return (a == MY_ADDR_A) || (a == MY_ADDR_B);
   endfunction : mine

   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : nxt

   function automatic logic exp_flag(input logic m9, input logic mce, input logic nb, input logic re);
      return re & (~m9 | ~mce | nb);
   endfunction : exp_flag

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      wb(1'b0, CTRL_ADDR, 8'h00);
      chk(rdat, 32'h40);
      wb(1'b1, CTRL_ADDR, 8'hbc);
      wb(1'b0, CTRL_ADDR, 8'h00);
      chk(rdat, 32'hfc);
      wb(1'b1, 12'h100, 8'h5a);
      wb(1'b0, 12'h100, 8'h00);
      chk(rdat, 32'h0);
      // transmit in both modes, receiver off, busy write dropped
      for (int m = 0; m < 2; m++) begin
         lfsr = nxt(lfsr);
         nine <= m[0];
         irq_en <= lfsr[8];
         wb(1'b1, CTRL_ADDR, {m[0], 3'b000, lfsr[9], 3'b000});
         n0 = rx_count;
         wb(1'b1, DATA_ADDR, lfsr[7:0]);
         wb(1'b1, DATA_ADDR, ~lfsr[7:0]);
         for (int n = 0; n < 300 && rx_count == n0; n++) @(posedge clk);
         chk(32'(prx_d), 32'(lfsr[7:0]));
         chk(32'(prx_ninth), 32'(m[0] & lfsr[9]));
         chk(32'(prx_stop), 32'h1);
         repeat (200) @(posedge clk);
         chk(rx_count, n0 + 1);
         wb(1'b0, CTRL_ADDR, 8'h00);
         chk(32'(rdat[BIT_TI]), 32'h1);
         chk(32'(irq), 32'(irq_en));
         wb(1'b1, CTRL_ADDR, 8'h00);
         // Clear lands at the ack edge; look one edge later
         @(posedge clk);
         chk(32'(irq), 32'h0);
      end
      // receive over every mode, enable and ninth bit
      for (int i = 0; i < 9; i++) begin
         lfsr = nxt(lfsr);
         ren = (i != 8);
         nine <= i[2];
         irq_en <= lfsr[8];
         wb(1'b1, CTRL_ADDR, {i[2], 1'b0, i[1], ren, 4'h0});
         psend(lfsr[7:0], i[0]);
         f = exp_flag(i[2], i[1], i[0], ren);
         wb(1'b0, CTRL_ADDR, 8'h00);
         chk(32'(rdat[BIT_RI]), 32'(f));
         chk(32'(rdat[BIT_RB8]), 32'(ren & (~i[2] | i[0])));
         chk(32'(irq), 32'(irq_en & f));
         if (f) begin
            wb(1'b0, DATA_ADDR, 8'h00);
            chk(rdat, 32'(lfsr[7:0]));
         end
      end
      // slave owns two addresses; others' data stays quiet
      for (int k = 0; k < 4; k++) begin
         lfsr = nxt(lfsr);
         nine <= 1'b1;
         ad = (k < 2) ? (k[0] ? MY_ADDR_B : MY_ADDR_A) : {1'b1, lfsr[6:0]};
         wb(1'b1, CTRL_ADDR, 8'hb0);
         psend(ad, 1'b1);
         wb(1'b0, DATA_ADDR, 8'h00);
         chk(rdat, 32'(ad));
         f = mine(rdat[7:0]);
         wb(1'b1, CTRL_ADDR, f ? 8'h90 : 8'hb0);
         psend(lfsr[15:8], 1'b0);
         wb(1'b0, CTRL_ADDR, 8'h00);
         chk(32'(rdat[BIT_RI]), 32'(k < 2));
      end
      conclude();
   end
endmodule : uart_multiprocessor_control_tb
